// file: shared/prss_pkg.sv
package prss_pkg;
  // system clock rate
  localparam int CLK_HZ = 10000000;
  // oscillator settling time in microseconds
  localparam int T_OSC_SETTLE_US = 500;
  // receiver start-up time from sleep exit in microseconds
  localparam int T_RX_STARTUP_US = 1000;
  // reset hold time after release of causes in microseconds
  localparam int T_RESET_US = 100;
  // cycle counts derived from the times, with the clock rate truncated to whole MHz
  localparam int OSC_SETTLE_CYC = (T_OSC_SETTLE_US * (CLK_HZ / 1000000));
  localparam int RX_STARTUP_CYC = (T_RX_STARTUP_US * (CLK_HZ / 1000000));
  localparam int RESET_CYC = (T_RESET_US * (CLK_HZ / 1000000));
  // timer width
  localparam int TMR_W = 24;
  // clock divider width and reset factor
  localparam int DIV_W = 20;
  localparam logic [19:0] DIV_RST = 20'h00007;
  // interrupt status width and value loaded on reset exit
  localparam int IS_W = 8;
  localparam logic [7:0] IS_RST = 8'hff;
  // serial number width
  localparam int SN_W = 32;
  // sequencer states
  typedef enum logic [4:0] {
    PRSS_RESET = 5'h01,
    PRSS_SLEEP = 5'h02,
    PRSS_SETTLE = 5'h04,
    PRSS_STARTUP = 5'h08,
    PRSS_READY = 5'h10
  } prss_state_t;
endpackage

// file: hdl/prss_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module prss_sequencer
  import prss_pkg::*;
#(
  parameter int OSC_SETTLE = OSC_SETTLE_CYC,
  parameter int RX_STARTUP = RX_STARTUP_CYC,
  parameter int RESET_HOLD = RESET_CYC,
  // arbitrary neutral serial number
  parameter logic [31:0] SERIAL_NUMBER = 32'h12345678
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // power-on pin, asynchronous
  input wire logic powerOn,
  // brown-out detector on the digital supply, asynchronous
  input wire logic digitalSupplyLow,
  // supply between brown-out and functional threshold
  input wire logic digitalSupplyMarginal,
  // oscillator running indication, asynchronous
  input wire logic oscRunning,
  // request to leave sleep (run) and to return (low)
  input wire logic runRequest,
  // interrupt status read strobe and events to set bits
  input wire logic statusRead,
  input wire logic [7:0] statusSet,
  // clock output enable and division factor
  input wire logic clkOutEnable,
  input wire logic [19:0] clkDivFactor,
  // alternative function selects for three pins
  input wire logic selAltClkPin,
  input wire logic selAltRunPin,
  input wire logic selAltIrqPin,
  // received data and strobe from the datapath
  input wire logic rxData,
  input wire logic rxStrobe,
  output logic digitalRegEn,
  output logic analogRegEn,
  output logic oscHighPrecision,
  output logic oscCapsConnected,
  output logic rfPathEn,
  output logic synthEn,
  output logic rxReady,
  output logic coreRst_n,
  output logic [7:0] interrupt_status_reg,
  output logic [31:0] serialNumber,
  output logic divided_clock_out,
  output logic runIndicatorOut,
  output logic irq_or_strobe_out
);
  // synchroniser stages for asynchronous inputs
  logic [2:0] ponSync_r, ponSync_nxt;
  logic [2:0] bodSync_r, bodSync_nxt;
  logic [2:0] midSync_r, midSync_nxt;
  logic [2:0] oscSync_r, oscSync_nxt;
  // filtered levels
  logic pon_r, pon_nxt;
  logic bod_r, bod_nxt;
  logic mid_r, mid_nxt;
  logic osc_r, osc_nxt;
  // sequencer state and timer
  prss_state_t state_r, state_nxt;
  logic [23:0] tmr_r, tmr_nxt;
  logic [23:0] rstTmr_r, rstTmr_nxt;
  logic coreRst_r, coreRst_nxt;
  // interrupt status and first-read flag
  logic [7:0] stat_r, stat_nxt;
  logic irqLow_r, irqLow_nxt;
  // clock divider
  logic [19:0] divCnt_r, divCnt_nxt;
  logic clkDiv_r, clkDiv_nxt;
  // registered pin outputs
  logic clkPin_r, clkPin_nxt;
  logic runPin_r, runPin_nxt;
  logic irqPin_r, irqPin_nxt;
  logic resetCause;

  // filter: change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // true in any run state of the sequencer
  function automatic logic is_running(input prss_state_t s);
    is_running = (s == PRSS_SETTLE) || (s == PRSS_STARTUP) ||
      (s == PRSS_READY);
  endfunction

  // synchroniser next values
  always_comb begin
    ponSync_nxt = {ponSync_r[1:0], powerOn};
    bodSync_nxt = {bodSync_r[1:0], digitalSupplyLow};
    midSync_nxt = {midSync_r[1:0], digitalSupplyMarginal};
    oscSync_nxt = {oscSync_r[1:0], oscRunning};
    pon_nxt = filt(ponSync_r, pon_r);
    bod_nxt = filt(bodSync_r, bod_r);
    mid_nxt = filt(midSync_r, mid_r);
    osc_nxt = filt(oscSync_r, osc_r);
  end

  // synchroniser registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ponSync_r <= 3'h0;
      bodSync_r <= 3'h0;
      midSync_r <= 3'h0;
      oscSync_r <= 3'h0;
      pon_r <= 1'b0;
      bod_r <= 1'b0;
      mid_r <= 1'b0;
      osc_r <= 1'b0;
    end else begin
      ponSync_r <= ponSync_nxt;
      bodSync_r <= bodSync_nxt;
      midSync_r <= midSync_nxt;
      oscSync_r <= oscSync_nxt;
      pon_r <= pon_nxt;
      bod_r <= bod_nxt;
      mid_r <= mid_nxt;
      osc_r <= osc_nxt;
    end
  end

  assign resetCause = !pon_r || bod_r;

  // reset generator and sequencer next state
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    rstTmr_nxt = rstTmr_r;
    coreRst_nxt = coreRst_r;
    stat_nxt = stat_r;
    irqLow_nxt = irqLow_r;
    if (resetCause) begin
      // any cause restarts the reset hold
      coreRst_nxt = 1'b1;
      rstTmr_nxt = 24'h000000;
      state_nxt = PRSS_RESET;
      tmr_nxt = 24'h000000;
    end else if (coreRst_r) begin
      if (osc_r && rstTmr_r >= 24'(RESET_HOLD - 1)) begin
        coreRst_nxt = 1'b0;
        // status all ones, interrupt held low
        stat_nxt = IS_RST;
        irqLow_nxt = 1'b1;
        state_nxt = PRSS_SLEEP;
      end else if (osc_r) begin
        rstTmr_nxt = rstTmr_r + 24'h000001;
      end
    end else begin
      // status read clears, new events win over clear
      if (statusRead) begin
        stat_nxt = statusSet;
        // first read releases the interrupt pin
        irqLow_nxt = 1'b0;
      end else begin
        stat_nxt = stat_r | statusSet;
      end
      unique case (state_r)
        PRSS_RESET: begin
          state_nxt = PRSS_SLEEP;
        end
        PRSS_SLEEP: begin
          if (runRequest) begin
            state_nxt = PRSS_SETTLE;
            tmr_nxt = 24'h000001;
          end
        end
        PRSS_SETTLE: begin
          tmr_nxt = tmr_r + 24'h000001;
          if (!runRequest) begin
            state_nxt = PRSS_SLEEP;
          end else if (tmr_r >= 24'(OSC_SETTLE)) begin
            state_nxt = PRSS_STARTUP;
          end
        end
        PRSS_STARTUP: begin
          tmr_nxt = tmr_r + 24'h000001;
          if (!runRequest) begin
            state_nxt = PRSS_SLEEP;
          end else if (tmr_r >= 24'(RX_STARTUP)) begin
            state_nxt = PRSS_READY;
          end
        end
        PRSS_READY: begin
          if (!runRequest) begin
            state_nxt = PRSS_SLEEP;
          end
        end
        default: begin
          state_nxt = PRSS_SLEEP;
        end
      endcase
    end
  end

  // clock divider and pin mux next values
  always_comb begin
    divCnt_nxt = divCnt_r;
    clkDiv_nxt = clkDiv_r;
    // divide by factor, then toggle for half duty
    if (coreRst_r || !clkOutEnable) begin
      divCnt_nxt = 20'h00000;
      clkDiv_nxt = 1'b0;
    end else if (divCnt_r >= clkDivFactor - 20'h00001) begin
      divCnt_nxt = 20'h00000;
      clkDiv_nxt = !clkDiv_r;
    end else begin
      divCnt_nxt = divCnt_r + 20'h00001;
    end
    clkPin_nxt = selAltClkPin ? rxData : clkDiv_r;
    // run pin follows next state so it matches the analog regulator
    runPin_nxt = selAltRunPin ? rxData :
      (is_running(state_nxt) && !coreRst_nxt);
    if (coreRst_r) begin
      // high during reset hold after supply returns
      irqPin_nxt = !resetCause;
    end else if (mid_r || irqLow_r) begin
      irqPin_nxt = 1'b0;
    end else begin
      irqPin_nxt = selAltIrqPin ? rxStrobe : (stat_r == 8'h00);
    end
    if (mid_r) begin
      irqPin_nxt = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PRSS_RESET;
      tmr_r <= 24'h000000;
      rstTmr_r <= 24'h000000;
      coreRst_r <= 1'b1;
      stat_r <= 8'h00;
      irqLow_r <= 1'b0;
      divCnt_r <= 20'h00000;
      clkDiv_r <= 1'b0;
      clkPin_r <= 1'b0;
      runPin_r <= 1'b0;
      irqPin_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      rstTmr_r <= rstTmr_nxt;
      coreRst_r <= coreRst_nxt;
      stat_r <= stat_nxt;
      irqLow_r <= irqLow_nxt;
      divCnt_r <= divCnt_nxt;
      clkDiv_r <= clkDiv_nxt;
      clkPin_r <= clkPin_nxt;
      runPin_r <= runPin_nxt;
      irqPin_r <= irqPin_nxt;
    end
  end

  assign digitalRegEn = pon_r;
  assign analogRegEn = is_running(state_r) && !coreRst_r;
  assign oscHighPrecision = !coreRst_r && state_r != PRSS_SLEEP &&
    state_r != PRSS_RESET;
  assign oscCapsConnected = oscHighPrecision;
  // analog path and synthesizer after settling
  assign rfPathEn = !coreRst_r &&
    (state_r == PRSS_STARTUP || state_r == PRSS_READY);
  assign synthEn = rfPathEn;
  assign rxReady = !coreRst_r && state_r == PRSS_READY;
  assign coreRst_n = !coreRst_r;
  assign interrupt_status_reg = stat_r;
  assign serialNumber = SERIAL_NUMBER;
  assign divided_clock_out = clkPin_r;
  assign runIndicatorOut = runPin_r;
  assign irq_or_strobe_out = irqPin_r;
endmodule
`default_nettype wire

// file: verification/prss_sequencer_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ties sequencing outputs to their causes at the pins
module prss_sequencer_chk
  import prss_pkg::*;
#(
  parameter int OSC_SETTLE = 8,
  parameter int RX_STARTUP = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic powerOn,
  input wire logic digitalSupplyLow,
  input wire logic digitalSupplyMarginal,
  input wire logic oscRunning,
  input wire logic selAltIrqPin,
  input wire logic selAltRunPin,
  input wire logic runIndicatorOut,
  input wire logic digitalRegEn,
  input wire logic analogRegEn,
  input wire logic oscHighPrecision,
  input wire logic oscCapsConnected,
  input wire logic rfPathEn,
  input wire logic rxReady,
  input wire logic coreRst_n,
  input wire logic [7:0] interrupt_status_reg,
  input wire logic irq_or_strobe_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_power_down: assert property (
    !powerOn [*6] |-> !digitalRegEn) else $error("regulator on at power-down");
  a_analog_run: assert property (
    analogRegEn |-> oscHighPrecision && coreRst_n) else $error("analog on idle");
  a_analog_pin: assert property (
    !$past(selAltRunPin) |-> analogRegEn == runIndicatorOut)
    else $error("analog regulator and run pin differ");
  a_brownout_reset: assert property (
    digitalSupplyLow [*6] |-> !coreRst_n) else $error("no brown-out reset");
  a_sleep_caps: assert property (
    !oscHighPrecision |-> !oscCapsConnected) else $error("caps on in sleep");
  a_settle_wait: assert property (
    $rose(rfPathEn) |-> $past(oscHighPrecision, OSC_SETTLE)
      && !$past(oscHighPrecision, OSC_SETTLE + 1)) else $error("rf too early");
  a_startup_ready: assert property (
    $rose(rxReady) |-> rfPathEn && $past(oscHighPrecision, RX_STARTUP)
      && !$past(oscHighPrecision, RX_STARTUP + 1)) else $error("ready timing");
  a_exit_status: assert property (
    $rose(coreRst_n) |-> ##2 (interrupt_status_reg == 8'hff
      && !irq_or_strobe_out)) else $error("status not set on exit");
  a_band_irq: assert property (
    (digitalSupplyMarginal && !selAltIrqPin) [*6] |-> !irq_or_strobe_out)
    else $error("irq high in brown-out band");
  a_osc_release: assert property (
    $rose(coreRst_n) |-> $past(oscRunning, 4)) else $error("reset left early");
endmodule
bind prss_sequencer prss_sequencer_chk #(.OSC_SETTLE(OSC_SETTLE),
  .RX_STARTUP(RX_STARTUP)) u_chk (.core_clk, .rst_n, .powerOn,
  .digitalSupplyLow, .digitalSupplyMarginal, .oscRunning, .selAltIrqPin,
  .selAltRunPin, .runIndicatorOut,
  .digitalRegEn, .analogRegEn, .oscHighPrecision, .oscCapsConnected,
  .rfPathEn, .rxReady, .coreRst_n, .interrupt_status_reg, .irq_or_strobe_out);
`default_nettype wire

// file: verification/prss_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: holds power-on low at start and on a reset request
module prss_host_model #(
  parameter int MIN_LOW = 6
) (
  input wire logic core_clk,
  input wire logic resetReq,
  output logic powerOn
);
  int lowCnt = MIN_LOW; // cycles of low pulse left
  // low pulse no shorter than minimum
  always @(posedge core_clk) begin
    if (lowCnt != 0) begin
      lowCnt <= lowCnt - 1;
    end else if (resetReq) begin
      lowCnt <= MIN_LOW;
    end
  end
  assign powerOn = (lowCnt == 0);
endmodule
`default_nettype wire

// file: verification/power_reset_sleep_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module power_reset_sleep_sequencer_tb;
  import prss_pkg::*;
  localparam int OSC = 8;
  localparam int RXS = 16;
  localparam logic [31:0] SN = 32'h5a5a0f0f; // arbitrary value
  logic core_clk, rst_n, powerOn, digitalSupplyLow, digitalSupplyMarginal;
  logic oscRunning, runRequest, statusRead, clkOutEnable, hostResetReq;
  logic selAltClkPin, selAltRunPin, selAltIrqPin, rxData, rxStrobe;
  logic digitalRegEn, analogRegEn, oscHighPrecision, oscCapsConnected;
  logic rfPathEn, synthEn, rxReady, coreRst_n, runIndicatorOut;
  logic divided_clock_out, irq_or_strobe_out;
  logic [7:0] statusSet, interrupt_status_reg, exp;
  logic [19:0] clkDivFactor;
  logic [31:0] serialNumber;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 49407;
  int k, t;
  prss_sequencer #(.OSC_SETTLE(OSC), .RX_STARTUP(RXS), .RESET_HOLD(4),
    .SERIAL_NUMBER(SN)) dut_u (.core_clk, .rst_n, .powerOn, .digitalSupplyLow,
    .digitalSupplyMarginal, .oscRunning, .runRequest, .statusRead, .statusSet,
    .clkOutEnable, .clkDivFactor, .selAltClkPin, .selAltRunPin, .selAltIrqPin,
    .rxData, .rxStrobe, .digitalRegEn, .analogRegEn, .oscHighPrecision,
    .oscCapsConnected, .rfPathEn, .synthEn, .rxReady, .coreRst_n,
    .interrupt_status_reg, .serialNumber, .divided_clock_out, .runIndicatorOut,
    .irq_or_strobe_out);
  prss_host_model host_u (.core_clk, .resetReq(hostResetReq), .powerOn);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // status after one cycle: a read clears, set wins
  function automatic logic [7:0] next_status(logic [7:0] s, set, logic rd);
    return rd ? set : (s | set);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bounded wait for internal reset to reach a level
  task automatic wait_rst(input logic v);
    for (t = 0; t < 300 && coreRst_n !== v; t++) tick();
    check("coreRst_n wait", coreRst_n, v);
    if (coreRst_n !== v) test_done();
  endtask
  // leave sleep, follow the ramp cycle by cycle, then fall back
  task automatic walk(input int stop);
    int j;
    runRequest = 1'b1;
    for (j = 1; j <= stop; j++) begin
      tick();
      check("precision", oscHighPrecision, 1);
      check("caps", oscCapsConnected, 1);
      check("analog", analogRegEn, 1);
      check("run pin", runIndicatorOut, 1);
      check("rfPath", rfPathEn, j >= OSC + 1);
      check("synth", synthEn, j >= OSC + 1);
      check("ready", rxReady, j >= RXS + 1);
    end
    runRequest = 1'b0;
    tick(2);
    check("sleep precision", oscHighPrecision, 0);
    check("sleep analog", analogRegEn, 0);
    check("sleep run pin", runIndicatorOut, 0);
  endtask
  // measure one half period of the divided clock
  task automatic half_period(input int f);
    logic last;
    int n;
    clkDivFactor = 20'(f);
    tick(4 * f + 4);
    repeat (2) begin
      last = divided_clock_out;
      for (n = 0; n < 50 && divided_clock_out === last; n++) tick();
    end
    check("half period", n, f);
  endtask
  initial begin
    {rst_n, digitalSupplyLow, digitalSupplyMarginal, oscRunning} = 4'h0;
    {runRequest, statusRead, statusSet, hostResetReq} = 11'h000;
    {selAltClkPin, selAltRunPin, selAltIrqPin, rxData, rxStrobe} = 5'h00;
    clkOutEnable = 1'b1;
    clkDivFactor = 20'h00007;
    tick(12);
    check("reset coreRst_n", coreRst_n, 0);
    rst_n = 1'b1;
    tick(3);
    oscRunning = 1'b1;
    wait_rst(1'b1);
    tick(2);
    check("digitalRegEn", digitalRegEn, 1);
    check("status", interrupt_status_reg, 8'hff);
    check("irq", irq_or_strobe_out, 0);
    check("sleep", oscHighPrecision, 0);
    check("serial", serialNumber, SN);
    statusRead = 1'b1;
    tick();
    statusRead = 1'b0;
    tick();
    check("irq read", irq_or_strobe_out, 1);
    digitalSupplyMarginal = 1'b1;
    tick(6);
    check("band irq", irq_or_strobe_out, 0);
    digitalSupplyLow = 1'b1;
    tick(8);
    check("brown coreRst_n", coreRst_n, 0);
    {digitalSupplyLow, digitalSupplyMarginal} = 2'h0;
    wait_rst(1'b1);
    tick(2);
    check("brown status", interrupt_status_reg, 8'hff);
    exp = IS_RST;
    for (k = 0; k < 40; k++) begin
      {statusRead, statusSet} = 9'($random(seed));
      exp = next_status(exp, statusSet, statusRead);
      tick();
      check("status", interrupt_status_reg, exp);
    end
    // plain read with no events clears status and frees the irq pin
    {statusRead, statusSet} = 9'h100;
    tick();
    check("status clear", interrupt_status_reg, 8'h00);
    {statusRead, statusSet} = 9'h000;
    walk(RXS + 3);
    walk(OSC);
    walk(1 + ($random(seed) & 15));
    for (k = 1; k < 4; k++) half_period(k);
    {selAltClkPin, selAltRunPin, selAltIrqPin} = 3'h7;
    for (k = 0; k < 8; k++) begin
      {rxData, rxStrobe} = 2'($random(seed));
      tick(2);
      check("clk pin", divided_clock_out, rxData);
      check("run pin", runIndicatorOut, rxData);
      check("irq pin", irq_or_strobe_out, rxStrobe);
    end
    {selAltClkPin, selAltRunPin, selAltIrqPin} = 3'h0;
    hostResetReq = 1'b1;
    tick();
    hostResetReq = 1'b0;
    tick(5);
    check("off digitalRegEn", digitalRegEn, 0);
    check("off coreRst_n", coreRst_n, 0);
    wait_rst(1'b1);
    tick(2);
    check("again sleep", oscHighPrecision, 0);
    test_done();
  end
endmodule
`default_nettype wire
